// ### ptm_defs.vh
// Register map, field positions, reset values and encodings of the periodic timer
`ifndef PTM_DEFS_VH
`define PTM_DEFS_VH
`define PTM_OFF_CTRL0 12'h000
`define PTM_OFF_CTRL1 12'h004
`define PTM_OFF_CNT_LO 12'h008
`define PTM_OFF_CNT_HI 12'h00c
`define PTM_OFF_DUTY_LO 12'h010
`define PTM_OFF_DUTY_HI 12'h014
`define PTM_OFF_PER_LO 12'h018
`define PTM_OFF_PER_HI 12'h01c
`define PTM_OFF_FLAGS 12'h020
`define PTM_OFF_PIN 12'h024
`define PTM_CTRL0_PAUSE 7
`define PTM_CTRL0_CKSEL_HI 6
`define PTM_CTRL0_CKSEL_LO 4
`define PTM_CTRL0_ENABLE 3
`define PTM_CTRL1_MODE_HI 7
`define PTM_CTRL1_MODE_LO 6
`define PTM_CTRL1_PINF_HI 5
`define PTM_CTRL1_PINF_LO 4
`define PTM_CTRL1_OC 3
`define PTM_CTRL1_POL 2
`define PTM_CTRL1_CCLR 0
`define PTM_FLAG_DUTY 0
`define PTM_FLAG_PERIOD 1
`define PTM_RESET_BYTE 8'h00
`define PTM_MODE_CMP 2'h0
`define PTM_MODE_PWM 2'h2
`define PTM_MODE_TMR 2'h3
`define PTM_PINF_NONE 2'h0
`define PTM_PINF_LOW 2'h1
`define PTM_PINF_HIGH 2'h2
`define PTM_PINF_TOGGLE 2'h3
`define PTM_CK_PIN_RISE 3'h6
`define PTM_CK_PIN_FALL 3'h7
`define PTM_CNT_MAX 10'h3ff
`endif

// ### ptm_load.sv
// Load model on the timer output pin
`timescale 1ns/100ps
module ptm_load (
  input wire clk,
  input wire clr,
  input wire pin,
  output logic [15:0] hi,
  output logic [15:0] rises
);
  logic last = 1'b0;
  // Passive load: it only counts, never drives back
  always @(posedge clk) begin
    last <= pin;
    hi <= clr ? 16'h0 : hi + {15'h0, pin};
    rises <= clr ? 16'h0 : rises + {15'h0, pin & ~last};
  end
endmodule // ptm_load

// ### ptm_timer.v
// Periodic 10-bit timer with compare, PWM and single-pulse output, APB slave
`timescale 1ns/100ps
`include "ptm_defs.vh"
//
// Contract
// - Mode 00: compare output, three clear sources
// - Clear-select low: period match clears, both flags
// - Clear-select high: duty match clears, duty flag
// - Zero duty: overflow at 3FF, no flag
// - Only duty match and enable rise change pin in compare
// - Duty match drives pin per pin function
// - Pin function: none, low, high, toggle
// - Enable rise loads pin initial level
// - Enable rise zeroes counter; fall keeps value
// - Mode 11 like compare, pin unused
// - PWM: period match clears, clear-select ignored
// - Period zero means 1024 counts
// - Duty at or above period gives 100%
// - PWM raises duty and period flags
// - Functions 00/01 force pin, counting continues
// - Output-control picks active level; polarity inverts
// - Clock-pin edge sets enable, starts pulse
// - Duty match clears enable, ends pulse, flags
// - Single pulse: counter zeroed only by enable
// - Compare values split low/high, upper bits zero
// - Clear-select encoding; overflow only if the selected compare value (period, or duty with clear-select high) is zero
module ptm_timer #(
  parameter CNT_W = 10
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire tick_fsys,
  input wire tick_fsys_div4,
  input wire tick_fh_div16,
  input wire tick_fh_div64,
  input wire tick_fsub,
  input wire external_clock_pin,
  output reg timer_output_pin,
  output reg timer_output_en,
  output reg duty_match_flag,
  output reg period_match_flag
);
  reg [7:0] ctrl0_q;
  reg [7:0] ctrl1_q;
  reg [CNT_W-1:0] duty_compare_value_q;
  reg [CNT_W-1:0] period_compare_value_q;
  reg [CNT_W-1:0] count_q;
  reg [CNT_W-1:0] count_d;
  reg en_prev_q;
  reg pin_q;
  reg pin_d;
  reg ck_prev_q;
  reg duty_flag_q;
  reg per_flag_q;
  reg set_duty_flag;
  reg set_per_flag;
  reg hw_set_en;
  reg hw_clr_en;
  reg tick;
  reg [31:0] rdata_d;
  reg err_d;

  wire [1:0] mode_field = ctrl1_q[`PTM_CTRL1_MODE_HI:`PTM_CTRL1_MODE_LO];
  wire [1:0] pin_function_field = ctrl1_q[`PTM_CTRL1_PINF_HI:`PTM_CTRL1_PINF_LO];
  wire output_control_bit = ctrl1_q[`PTM_CTRL1_OC];
  wire output_polarity_bit = ctrl1_q[`PTM_CTRL1_POL];
  wire clear_select_bit = ctrl1_q[`PTM_CTRL1_CCLR];
  wire timer_enable_bit = ctrl0_q[`PTM_CTRL0_ENABLE];
  wire pause_bit = ctrl0_q[`PTM_CTRL0_PAUSE];
  wire [2:0] ck_sel = ctrl0_q[`PTM_CTRL0_CKSEL_HI:`PTM_CTRL0_CKSEL_LO];
  wire is_pwm = (mode_field == `PTM_MODE_PWM);
  wire is_single = is_pwm && (pin_function_field == `PTM_PINF_TOGGLE);
  wire is_cmp = (mode_field == `PTM_MODE_CMP) || (mode_field == `PTM_MODE_TMR);
  wire en_rise = timer_enable_bit && !en_prev_q;
  wire running = timer_enable_bit && !pause_bit && !en_rise;
  wire duty_hit = (count_q == duty_compare_value_q);
  wire per_hit = (count_q == period_compare_value_q);
  wire at_max = (count_q == `PTM_CNT_MAX);
  // Next count; PWM period ends where it meets the period value, so zero wraps at 1024
  wire [CNT_W-1:0] count_inc = count_q + 1'b1;
  wire wr_acc = psel && penable && pwrite;
  wire setup = psel && !penable;
  // Active level before polarity; duty at or above period never goes inactive
  wire pwm_active = (duty_compare_value_q >= period_compare_value_q) &&
                    (period_compare_value_q != {CNT_W{1'b0}}) ? 1'b1 :
                    (count_q < duty_compare_value_q);

  // Clock source is a pin edge or an internal tick supplied by the clock unit
  always @* begin
    case (ck_sel)
      3'h0: tick = tick_fsys_div4;
      3'h1: tick = tick_fsys;
      3'h2: tick = tick_fh_div16;
      3'h3: tick = tick_fh_div64;
      `PTM_CK_PIN_RISE: tick = external_clock_pin && !ck_prev_q;
      `PTM_CK_PIN_FALL: tick = !external_clock_pin && ck_prev_q;
      default: tick = tick_fsub;
    endcase
  end

  always @* begin
    count_d = count_q;
    pin_d = pin_q;
    set_duty_flag = 1'b0;
    set_per_flag = 1'b0;
    hw_clr_en = 1'b0;
    hw_set_en = 1'b0;
    if (is_single && !timer_enable_bit && ck_sel[2:1] == 2'h3 && tick)
      hw_set_en = 1'b1;
    if (en_rise) begin
      count_d = {CNT_W{1'b0}};
      pin_d = output_control_bit;
    end else if (running && tick) begin
      count_d = count_q + 1'b1;
      if (is_cmp) begin
        if (clear_select_bit) begin
          if (duty_compare_value_q != {CNT_W{1'b0}} && duty_hit) begin
            count_d = {CNT_W{1'b0}};
            set_duty_flag = 1'b1;
          end else if (at_max)
            count_d = {CNT_W{1'b0}};
        end else begin
          if (duty_hit && duty_compare_value_q != {CNT_W{1'b0}})
            set_duty_flag = 1'b1;
          if (period_compare_value_q != {CNT_W{1'b0}} && per_hit) begin
            count_d = {CNT_W{1'b0}};
            set_per_flag = 1'b1;
          end else if (at_max) begin
            count_d = {CNT_W{1'b0}};
            if (period_compare_value_q == {CNT_W{1'b0}})
              set_per_flag = 1'b1;
          end
        end
        if (set_duty_flag && mode_field == `PTM_MODE_CMP) begin
          case (pin_function_field)
            `PTM_PINF_LOW: pin_d = 1'b0;
            `PTM_PINF_HIGH: pin_d = 1'b1;
            `PTM_PINF_TOGGLE: pin_d = !pin_q;
            default: pin_d = pin_q;
          endcase
        end
      end else if (is_single) begin
        if (duty_hit) begin
          count_d = count_q;
          set_duty_flag = 1'b1;
          hw_clr_en = 1'b1;
        end
      end else if (is_pwm) begin
        if (duty_hit)
          set_duty_flag = 1'b1;
        if (count_inc == period_compare_value_q) begin
          count_d = {CNT_W{1'b0}};
          set_per_flag = 1'b1;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= `PTM_RESET_BYTE;
      ctrl1_q <= `PTM_RESET_BYTE;
      duty_compare_value_q <= {CNT_W{1'b0}};
      period_compare_value_q <= {CNT_W{1'b0}};
      count_q <= {CNT_W{1'b0}};
      en_prev_q <= 1'b0;
      pin_q <= 1'b0;
      ck_prev_q <= 1'b0;
      duty_flag_q <= 1'b0;
      per_flag_q <= 1'b0;
    end else begin
      en_prev_q <= timer_enable_bit;
      ck_prev_q <= external_clock_pin;
      count_q <= count_d;
      pin_q <= pin_d;
      // Hardware set beats a software clear in the same cycle
      duty_flag_q <= set_duty_flag ||
        (duty_flag_q && !(wr_acc && paddr == `PTM_OFF_FLAGS && pwdata[`PTM_FLAG_DUTY]));
      per_flag_q <= set_per_flag ||
        (per_flag_q && !(wr_acc && paddr == `PTM_OFF_FLAGS && pwdata[`PTM_FLAG_PERIOD]));
      if (wr_acc) begin
        case (paddr)
          `PTM_OFF_CTRL0: ctrl0_q <= {pwdata[7:3], 3'h0};
          `PTM_OFF_CTRL1: ctrl1_q <= pwdata[7:0];
          `PTM_OFF_DUTY_LO: duty_compare_value_q[7:0] <= pwdata[7:0];
          `PTM_OFF_DUTY_HI: duty_compare_value_q[CNT_W-1:8] <= pwdata[CNT_W-9:0];
          `PTM_OFF_PER_LO: period_compare_value_q[7:0] <= pwdata[7:0];
          `PTM_OFF_PER_HI: period_compare_value_q[CNT_W-1:8] <= pwdata[CNT_W-9:0];
          default: ctrl0_q <= ctrl0_q;
        endcase
      end
      // Automatic enable changes win over a simultaneous software write
      if (hw_set_en)
        ctrl0_q[`PTM_CTRL0_ENABLE] <= 1'b1;
      else if (hw_clr_en)
        ctrl0_q[`PTM_CTRL0_ENABLE] <= 1'b0;
    end
  end

  // Read mux; answer in the access cycle after one registered setup cycle
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      `PTM_OFF_CTRL0: rdata_d[7:0] = ctrl0_q;
      `PTM_OFF_CTRL1: rdata_d[7:0] = ctrl1_q;
      `PTM_OFF_CNT_LO: rdata_d[7:0] = count_q[7:0];
      `PTM_OFF_CNT_HI: rdata_d[CNT_W-9:0] = count_q[CNT_W-1:8];
      `PTM_OFF_DUTY_LO: rdata_d[7:0] = duty_compare_value_q[7:0];
      `PTM_OFF_DUTY_HI: rdata_d[CNT_W-9:0] = duty_compare_value_q[CNT_W-1:8];
      `PTM_OFF_PER_LO: rdata_d[7:0] = period_compare_value_q[7:0];
      `PTM_OFF_PER_HI: rdata_d[CNT_W-9:0] = period_compare_value_q[CNT_W-1:8];
      `PTM_OFF_FLAGS: rdata_d[1:0] = {per_flag_q, duty_flag_q};
      `PTM_OFF_PIN: rdata_d[0] = timer_output_pin;
      default: err_d = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      timer_output_pin <= 1'b0;
      timer_output_en <= 1'b0;
      duty_match_flag <= 1'b0;
      period_match_flag <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && err_d;
      prdata <= setup ? rdata_d : 32'h0000_0000;
      duty_match_flag <= duty_flag_q;
      period_match_flag <= per_flag_q;
      timer_output_en <= (mode_field != `PTM_MODE_TMR) && (mode_field != 2'h1);
      if (is_pwm && !is_single) begin
        case (pin_function_field)
          `PTM_PINF_NONE: timer_output_pin <= !output_control_bit ^ output_polarity_bit;
          `PTM_PINF_LOW: timer_output_pin <= output_control_bit ^ output_polarity_bit;
          default: timer_output_pin <=
            (pwm_active ~^ output_control_bit) ^ output_polarity_bit;
        endcase
      end else if (is_single)
        timer_output_pin <= (timer_enable_bit ~^ output_control_bit) ^ output_polarity_bit;
      else if (mode_field == `PTM_MODE_CMP)
        timer_output_pin <= pin_q ^ output_polarity_bit;
      else
        timer_output_pin <= 1'b0;
    end
  end
endmodule // ptm_timer

// ### ptm_timer_chk.sv
// Port checker for the periodic timer
`timescale 1ns/100ps
module ptm_timer_chk #(
  parameter CNT_W = 10
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire timer_output_pin,
  input wire duty_match_flag,
  input wire period_match_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Flags lag the clear write by up to two edges
  wire fw = psel && penable && pwrite && paddr == 12'h020;
  AST_RDY: assert property (psel && !penable |=> pready)
    else $error("no ready");
  AST_RDZ: assert property (!pready |-> prdata == 32'h0)
    else $error("data outside access");
  AST_UNM: assert property (pready && paddr > 12'h024 |-> pslverr)
    else $error("unmapped accepted");
  AST_MAP: assert property (pready && paddr == 12'h010 |-> !pslverr)
    else $error("mapped refused");
  AST_HI: assert property (pready && !pwrite && paddr == 12'h014 |-> prdata[31:2] == 30'h0)
    else $error("high bits set");
  AST_DFL: assert property ($fell(duty_match_flag) |-> $past(fw && pwdata[0]) || $past(fw && pwdata[0], 2))
    else $error("duty flag lost");
  AST_PFL: assert property ($fell(period_match_flag) |-> $past(fw && pwdata[1]) || $past(fw && pwdata[1], 2))
    else $error("period flag lost");
  AST_RST: assert property ($rose(presetn) |-> !timer_output_pin && !pready)
    else $error("outputs after reset");
  cover property (duty_match_flag && period_match_flag);
  cover property ($rose(timer_output_pin));
  cover property (pslverr);
endmodule // ptm_timer_chk
bind ptm_timer ptm_timer_chk #(.CNT_W(CNT_W)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_output_pin, .duty_match_flag,
  .period_match_flag);

// ### ptm_timer_tb.sv
// Self-checking bench for the periodic timer
`timescale 1ns/100ps
`include "ptm_defs.vh"
module ptm_timer_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic xp = 1'b0;
  logic clr = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, pin, pen, dfl, pfl;
  logic [15:0] hi, rises;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  initial forever #5 pclk = ~pclk;
  ptm_timer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tick_fsys(1'b1), .tick_fsys_div4(1'b0), .tick_fh_div16(1'b0),
    .tick_fh_div64(1'b0), .tick_fsub(1'b0), .external_clock_pin(xp), .timer_output_pin(pin),
    .timer_output_en(pen), .duty_match_flag(dfl), .period_match_flag(pfl));
  ptm_load u_load (.clk(pclk), .clr, .pin, .hi, .rises);
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input [31:0] s, input [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task apb(input [11:0] a, input w, input [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task run(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task lc;
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask
  // Mode changes only with the timer off
  task cfg(input [7:0] c1, input [7:0] d, input [7:0] p, input [7:0] c0);
    apb(`PTM_OFF_CTRL0, 1, 8'h00);
    apb(`PTM_OFF_DUTY_LO, 1, d);
    apb(`PTM_OFF_PER_LO, 1, p);
    apb(`PTM_OFF_CTRL1, 1, c1);
    apb(`PTM_OFF_FLAGS, 1, 8'h03);
    apb(`PTM_OFF_CTRL0, 1, c0);
  endtask
  task t_regs;
    for (int i = 0; i < 4; i++) begin
      apb(`PTM_OFF_DUTY_LO + 12'(4 * i), 0, 8'h00);
      chk(rd, 32'h0);
    end
    apb(`PTM_OFF_DUTY_HI, 1, 8'hff);
    apb(`PTM_OFF_DUTY_HI, 0, 8'h00);
    chk(rd, 32'h3);
    apb(`PTM_OFF_DUTY_HI, 1, 8'h00);
    apb(12'h0fc, 0, 8'h00);
    chk(er, 1'b1);
    $display("register test done");
  endtask
  task t_cmp;
    cfg(8'h39, 8'h04, 8'h02, 8'h18);
    run(2);
    chk(pin, 1'b1);
    lc;
    run(40);
    chk({dfl, pfl, pen}, 3'b101);
    chk(rises > 0, 1'b1);
    cfg(8'h18, 8'h01, 8'h02, 8'h18);
    run(20);
    chk({dfl, pfl, pin}, 3'b110);
    cfg(8'h21, 8'h04, 8'h02, 8'h18);
    run(20);
    chk(pin, 1'b1);
    cfg(8'hf1, 8'h04, 8'h02, 8'h18);
    run(20);
    chk({dfl, pfl, pen}, 3'b100);
    $display("compare test done");
  endtask
  // Window is a whole number of periods, so counts are exact
  task pw(input [7:0] c1, input [7:0] d, input [7:0] p, input int n, input [15:0] h,
    input [1:0] f);
    cfg(c1, d, p, 8'h18);
    run(16);
    lc;
    run(n);
    chk(hi, h);
    chk({dfl, pfl}, f);
  endtask
  task t_pwm;
    pw(8'ha8, 8'h02, 8'h08, 80, 16'h14, 2'h3);
    pw(8'ha9, 8'h02, 8'h08, 80, 16'h14, 2'h3);
    pw(8'ha8, 8'h09, 8'h08, 80, 16'h50, 2'h1);
    pw(8'hac, 8'h02, 8'h08, 80, 16'h3c, 2'h3);
    pw(8'h88, 8'h02, 8'h08, 80, 16'h00, 2'h3);
    pw(8'h98, 8'h02, 8'h08, 80, 16'h50, 2'h3);
    pw(8'ha8, 8'h80, 8'h00, 1024, 16'h80, 2'h3);
    $display("pwm test done");
  endtask
  task t_sp;
    cfg(8'hb8, 8'h05, 8'h00, 8'h00);
    lc;
    apb(`PTM_OFF_CTRL0, 1, 8'h18);
    run(40);
    chk({rises, dfl}, 17'h3);
    apb(`PTM_OFF_CTRL0, 0, 8'h00);
    chk(rd[3], 1'b0);
    cfg(8'hb8, 8'h05, 8'h00, 8'h60);
    lc;
    xp <= 1'b1;
    repeat (3) @(posedge pclk);
    xp <= 1'b0;
    run(4);
    chk({rises, pin}, 17'h3);
    apb(`PTM_OFF_CTRL0, 1, 8'h60);
    run(3);
    chk(pin, 1'b0);
    $display("single pulse test done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_cmp;
    t_pwm;
    t_sp;
    end_sim;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim;
    end
  end
endmodule // ptm_timer_tb
